// >>> hw/mbp_map.svh
`ifndef MBP_MAP_SVH
`define MBP_MAP_SVH

// Word addresses seen on AD[6:1]
`define CAP_BASE      6'h30
`define CAP_LAST      6'h3c
`define BUF_PORT      6'h3f

// Capture window indices, relative to CAP_BASE
`define CAP_BLK_LO    4'h8
`define CAP_BLK_HI    4'h9
`define CAP_BUFF_LO   4'ha
`define CAP_BUFF_HI   4'hb
`define CAP_STAT      4'hc

// Capture status bit positions
`define STAT_FULL_BIT 0
`define STAT_ARM_BIT  1

// Reset values
`define STROBE_IDLE   3'h7
`define SEL_IDLE      2'h0
`define ADDR_RST      6'h00
`define DATA_RST      8'h00

`endif

// >>> hw/mbp_pkg.sv
`default_nettype none

package mbp_pkg;

  // Access sequencing of the processor port
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REG_RD,
    ST_BUF_WAIT,
    ST_DRIVE,
    ST_WR_HOLD
  } port_state_t;

  // Where a latched address points
  typedef enum logic [1:0] {
    TGT_REG,
    TGT_CAP,
    TGT_BUF
  } target_t;

endpackage

`default_nettype wire

// >>> hw/id_capture.sv
`include "mbp_map.svh"
`default_nettype none

module id_capture #(
  parameter int ID_BYTES = 4
) (
  input  wire logic       core_clk,      // Core clock
  input  wire logic       nrst,          // Async reset, active low
  input  wire logic       id_byte_valid, // ID byte from disk side
  input  wire logic [7:0] id_byte,       // ID byte value
  input  wire logic       id_done,       // End of ID field
  input  wire logic       id_crc_good,   // ID CRC check result
  input  wire logic       cnt_update,    // Snapshot strobe for counts
  input  wire logic [15:0] block_count,  // Live external block count
  input  wire logic [15:0] buff_count,   // Live buffer count
  input  wire logic       wr_en,         // Processor write pulse
  input  wire logic [7:0] wr_data,       // Processor write data
  input  wire logic [3:0] rd_index,      // Window index
  output logic      [7:0] rd_data,       // Window read data
  output logic            id_full        // Complete good ID held
);
  import mbp_pkg::*;

  if (ID_BYTES < 1 || ID_BYTES > 8) begin : g_chk
    $error("id_capture: ID_BYTES must be 1 to 8");
  end

  typedef struct packed {
    logic [ID_BYTES-1:0][7:0] id;
    logic [3:0]               wp;
    logic                     armed;
    logic                     full;
    logic [15:0]              blk;
    logic [15:0]              bcnt;
  } cap_regs_t;

  localparam cap_regs_t CAP_RST = '{armed: 1'b1, default: '0};
  localparam logic [3:0] ID_LEN = 4'(ID_BYTES);

  cap_regs_t s_q;
  cap_regs_t s_d;

  // Capture, snapshot and processor control; a new ID beats a clear
  always_comb
  begin
    s_d = s_q;
    if (wr_en && rd_index == `CAP_STAT)
    begin
      if (wr_data[`STAT_FULL_BIT])
        s_d.full = 1'b0;
      if (wr_data[`STAT_ARM_BIT])
      begin
        s_d.armed = 1'b1;
        s_d.wp    = 4'h0;
      end
    end
    if (s_q.armed && id_byte_valid && s_q.wp < ID_LEN)
    begin
      s_d.id[s_q.wp] = id_byte;
      s_d.wp         = s_q.wp + 4'h1;
    end
    if (s_q.armed && id_done)
    begin
      // A bad CRC restarts the fill so stale bytes never look complete
      if (id_crc_good)
      begin
        s_d.full  = 1'b1;
        s_d.armed = 1'b0;
      end
      else
        s_d.wp = 4'h0;
    end
    if (cnt_update)
    begin
      s_d.blk  = block_count;
      s_d.bcnt = buff_count;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      s_q <= CAP_RST;
    else
      s_q <= s_d;
  end

  // Read window
  always_comb
  begin
    rd_data = 8'h00;
    if (rd_index < ID_LEN)
      rd_data = s_q.id[rd_index];
    else if (rd_index == `CAP_BLK_LO)
      rd_data = s_q.blk[7:0];
    else if (rd_index == `CAP_BLK_HI)
      rd_data = s_q.blk[15:8];
    else if (rd_index == `CAP_BUFF_LO)
      rd_data = s_q.bcnt[7:0];
    else if (rd_index == `CAP_BUFF_HI)
      rd_data = s_q.bcnt[15:8];
    else if (rd_index == `CAP_STAT)
      rd_data = {6'h00, s_q.armed, s_q.full};
  end

  assign id_full = s_q.full;

  property p_id_full_set;
    @(posedge core_clk) disable iff (!nrst)
    s_q.armed && id_done && id_crc_good |=> id_full && !s_q.armed;
  endproperty
  a_id_full_set: assert property (p_id_full_set)
    else $error("good ID did not set full flag");

  property p_count_snap;
    @(posedge core_clk) disable iff (!nrst)
    cnt_update |=> s_q.blk == $past(block_count)
                   && s_q.bcnt == $past(buff_count);
  endproperty
  a_count_snap: assert property (p_count_snap)
    else $error("count snapshot not taken");

endmodule // id_capture

`default_nettype wire

// >>> hw/mux_bus_processor_port.sv
// Functional notes
// - Address on AD[6:1] latched into the address latch when ALE pulses.
// - After address, data on AD[7:0] stored into latched register on write.
// - On read strobe the addressed register drives AD[7:0] while active.
// - Register accesses finish in one bus cycle, no wait states.
// - Indirect mode loads the address register before any data access.
// - Four interrupt outputs: three general lines plus buffer transfer line.
// - ID and count capture registers stay updated during skip-mask transfers.
`include "mbp_map.svh"
`default_nettype none

module mux_bus_processor_port #(
  parameter int ID_BYTES = 4
) (
  input  wire logic        core_clk,         // Core clock, 200 MHz
  input  wire logic        nrst,             // Async reset, active low
  input  wire logic [7:0]  ad_in,            // AD pins, input side
  output logic      [7:0]  ad_out,           // AD pins, output side
  output logic             ad_oe_n,          // AD drive enable, low drives
  input  wire logic        ale,              // Address latch strobe
  input  wire logic        cs_n,             // Chip select, active low
  input  wire logic        write_data_strobe_n, // Write strobe, low
  input  wire logic        read_data_strobe_n,  // Read strobe, low
  input  wire logic        indirect_mode,    // No-ALE addressing
  input  wire logic        indirect_data_sel, // 0 address, 1 data
  output logic             access_wait_ready, // Low extends strobe
  output logic      [5:0]  reg_addr,         // Internal register address
  output logic      [7:0]  reg_wdata,        // Internal write data
  output logic             reg_wr,           // Internal write pulse
  output logic             reg_rd,           // Internal read pulse
  input  wire logic [7:0]  reg_rdata,        // Read data, same cycle as reg_rd
  output logic             buf_wr,           // Buffer write pulse
  output logic             buf_rd,           // Buffer read request
  input  wire logic        buf_ack,          // Buffer slot or data ready
  input  wire logic [7:0]  buf_rdata,        // Buffer read data
  input  wire logic [2:0]  irq_src,          // Internal interrupt events
  input  wire logic        buf_xfer_src,     // Buffer transfer event
  output logic      [2:0]  interrupt_outputs, // Interrupt lines
  output logic             buffer_transfer_irq, // Buffer transfer line
  input  wire logic        id_byte_valid,    // ID byte from disk side
  input  wire logic [7:0]  id_byte,          // ID byte value
  input  wire logic        id_done,          // End of ID field
  input  wire logic        id_crc_good,      // ID CRC good
  input  wire logic        cnt_update,       // Count snapshot strobe
  input  wire logic [15:0] block_count,      // External block count
  input  wire logic [15:0] buff_count        // Buffer count
);
  import mbp_pkg::*;

  typedef struct packed {
    logic [2:0]  ale_s;
    logic [2:0]  wr_s;
    logic [2:0]  rd_s;
    logic [2:0]  cs_s;
    logic [1:0]  ind_s;
    logic [1:0]  sel_s;
    logic [7:0]  ad_s1;
    logic [7:0]  ad_s2;
    logic [5:0]  addr;
    port_state_t st;
    logic        is_wr;
    logic [7:0]  dout;
    logic        drive;
    logic        ready;
    logic        reg_wr;
    logic        reg_rd;
    logic        buf_wr;
    logic        buf_rd;
    logic        cap_wr;
    logic [7:0]  wdata;
    logic [2:0]  irq;
    logic        btf;
  } port_regs_t;

  localparam port_regs_t PORT_RST = '{
    wr_s: `STROBE_IDLE, rd_s: `STROBE_IDLE, cs_s: `STROBE_IDLE,
    ind_s: `SEL_IDLE, sel_s: `SEL_IDLE, addr: `ADDR_RST,
    dout: `DATA_RST, wdata: `DATA_RST, st: ST_IDLE, ready: 1'b1,
    default: '0};

  // Decode a word address into its target
  function automatic target_t decode(input logic [5:0] a);
    if (a == `BUF_PORT)
      return TGT_BUF;
    else if (a >= `CAP_BASE && a <= `CAP_LAST)
      return TGT_CAP;
    else
      return TGT_REG;
  endfunction

  port_regs_t s_q;
  port_regs_t s_d;
  logic [7:0] cap_rdata;
  logic       id_full;
  logic [5:0] cap_off;
  logic       ale_fall;
  logic       wr_fall;
  logic       wr_rise;
  logic       rd_fall;
  logic       cs_act;
  logic       ind;
  logic       data_phase;
  target_t    tgt;

  // Edges use the second and third sync stages only
  assign ale_fall   = s_q.ale_s[2] & ~s_q.ale_s[1];
  assign wr_fall    = s_q.wr_s[2] & ~s_q.wr_s[1];
  assign wr_rise    = ~s_q.wr_s[2] & s_q.wr_s[1];
  assign rd_fall    = s_q.rd_s[2] & ~s_q.rd_s[1];
  assign cs_act     = ~s_q.cs_s[1];
  assign ind        = s_q.ind_s[1];
  assign data_phase = ~ind | s_q.sel_s[1];
  assign tgt        = decode(s_q.addr);
  assign cap_off    = s_q.addr - `CAP_BASE;

  id_capture #(
    .ID_BYTES (ID_BYTES)
  ) u_cap (
    .core_clk      (core_clk),
    .nrst          (nrst),
    .id_byte_valid (id_byte_valid),
    .id_byte       (id_byte),
    .id_done       (id_done),
    .id_crc_good   (id_crc_good),
    .cnt_update    (cnt_update),
    .block_count   (block_count),
    .buff_count    (buff_count),
    .wr_en         (s_q.cap_wr),
    .wr_data       (s_q.wdata),
    .rd_index      (cap_off[3:0]),
    .rd_data       (cap_rdata),
    .id_full       (id_full)
  );

  // Synchronisers, address latch and access sequencing
  always_comb
  begin
    s_d        = s_q;
    s_d.reg_wr = 1'b0;
    s_d.reg_rd = 1'b0;
    s_d.buf_wr = 1'b0;
    s_d.buf_rd = 1'b0;
    s_d.cap_wr = 1'b0;
    s_d.ale_s  = {s_q.ale_s[1:0], ale};
    s_d.wr_s   = {s_q.wr_s[1:0], write_data_strobe_n};
    s_d.rd_s   = {s_q.rd_s[1:0], read_data_strobe_n};
    s_d.cs_s   = {s_q.cs_s[1:0], cs_n};
    s_d.ind_s  = {s_q.ind_s[0], indirect_mode};
    s_d.sel_s  = {s_q.sel_s[0], indirect_data_sel};
    s_d.ad_s1  = ad_in;
    s_d.ad_s2  = s_q.ad_s1;
    // ID full is folded into line 0 so capture needs no extra pin
    s_d.irq    = {irq_src[2:1], irq_src[0] | id_full};
    s_d.btf    = buf_xfer_src;
    if (!ind && ale_fall)
      s_d.addr = s_q.ad_s2[6:1];
    case (s_q.st)
      ST_IDLE:
      begin
        if (cs_act && rd_fall && data_phase)
        begin
          s_d.is_wr = 1'b0;
          if (tgt == TGT_BUF)
          begin
            s_d.buf_rd = 1'b1;
            s_d.ready  = 1'b0;
            s_d.st     = ST_BUF_WAIT;
          end
          else if (tgt == TGT_CAP)
          begin
            s_d.dout  = cap_rdata;
            s_d.drive = 1'b1;
            s_d.st    = ST_DRIVE;
          end
          else
          begin
            s_d.reg_rd = 1'b1;
            s_d.st     = ST_REG_RD;
          end
        end
        else if (cs_act && wr_fall && data_phase && tgt == TGT_BUF)
        begin
          s_d.is_wr = 1'b1;
          s_d.ready = 1'b0;
          s_d.st    = ST_BUF_WAIT;
        end
        else if (cs_act && wr_rise)
        begin
          if (ind && !s_q.sel_s[1])
            s_d.addr = s_q.ad_s2[6:1];
          else
          begin
            s_d.wdata  = s_q.ad_s2;
            s_d.reg_wr = (tgt == TGT_REG);
            s_d.cap_wr = (tgt == TGT_CAP);
          end
        end
      end
      ST_REG_RD:
      begin
        s_d.dout  = reg_rdata;
        s_d.drive = 1'b1;
        s_d.st    = ST_DRIVE;
      end
      ST_BUF_WAIT:
      begin
        // Processor is held here; the strobe cannot end before ready
        if (buf_ack)
        begin
          s_d.ready = 1'b1;
          if (s_q.is_wr)
            s_d.st = ST_WR_HOLD;
          else
          begin
            s_d.dout  = buf_rdata;
            s_d.drive = 1'b1;
            s_d.st    = ST_DRIVE;
          end
        end
      end
      ST_DRIVE:
      begin
        // Level test, so a short strobe seen in REG_RD is not missed
        if (s_q.rd_s[1])
        begin
          s_d.drive = 1'b0;
          s_d.st    = ST_IDLE;
        end
      end
      ST_WR_HOLD:
      begin
        if (s_q.wr_s[1])
        begin
          s_d.wdata  = s_q.ad_s2;
          s_d.buf_wr = 1'b1;
          s_d.st     = ST_IDLE;
        end
      end
      default:
        s_d.st = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      s_q <= PORT_RST;
    else
      s_q <= s_d;
  end

  assign ad_out              = s_q.dout;
  assign ad_oe_n             = ~s_q.drive;
  assign access_wait_ready   = s_q.ready;
  assign reg_addr            = s_q.addr;
  assign reg_wdata           = s_q.wdata;
  assign reg_wr              = s_q.reg_wr;
  assign reg_rd              = s_q.reg_rd;
  assign buf_wr              = s_q.buf_wr;
  assign buf_rd              = s_q.buf_rd;
  assign interrupt_outputs   = s_q.irq;
  assign buffer_transfer_irq = s_q.btf;

  sequence s_rd_start;
    s_q.st == ST_IDLE && cs_act && rd_fall && data_phase;
  endsequence

  sequence s_reg_target;
    tgt == TGT_REG;
  endsequence

  property p_addr_latch;
    @(posedge core_clk) disable iff (!nrst)
    !ind && ale_fall |=> reg_addr == $past(s_q.ad_s2[6:1]);
  endproperty
  a_addr_latch: assert property (p_addr_latch)
    else $error("address not latched on ALE");

  property p_reg_write;
    @(posedge core_clk) disable iff (!nrst)
    s_q.st == ST_IDLE && cs_act && wr_rise && !ind && tgt == TGT_REG
      && !rd_fall && !wr_fall
      |=> reg_wr && reg_wdata == $past(s_q.ad_s2);
  endproperty
  a_reg_write: assert property (p_reg_write)
    else $error("register write not issued");

  property p_read_drive;
    @(posedge core_clk) disable iff (!nrst)
    s_rd_start ##0 s_reg_target |=> reg_rd ##1
      (!ad_oe_n && ad_out == $past(reg_rdata));
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read data not driven");

  property p_no_wait;
    @(posedge core_clk) disable iff (!nrst)
    s_rd_start ##0 s_reg_target |=> access_wait_ready [*2];
  endproperty
  a_no_wait: assert property (p_no_wait)
    else $error("register access stalled");

  property p_indirect_load;
    @(posedge core_clk) disable iff (!nrst)
    s_q.st == ST_IDLE && cs_act && wr_rise && ind && !s_q.sel_s[1]
      && !rd_fall
      |=> reg_addr == $past(s_q.ad_s2[6:1]) && !reg_wr;
  endproperty
  a_indirect_load: assert property (p_indirect_load)
    else $error("indirect address not loaded");

  property p_irq_lines;
    @(posedge core_clk) disable iff (!nrst)
    buf_xfer_src && irq_src[2] |=> buffer_transfer_irq
      && interrupt_outputs[2];
  endproperty
  a_irq_lines: assert property (p_irq_lines)
    else $error("interrupt line not raised");

  property p_buf_hold;
    @(posedge core_clk) disable iff (!nrst)
    s_q.st == ST_BUF_WAIT && !buf_ack |=> !access_wait_ready;
  endproperty
  a_buf_hold: assert property (p_buf_hold)
    else $error("ready released before buffer data");

  property p_buf_release;
    @(posedge core_clk) disable iff (!nrst)
    s_q.st == ST_BUF_WAIT && buf_ack && !s_q.is_wr
      |=> access_wait_ready && !ad_oe_n && ad_out == $past(buf_rdata);
  endproperty
  a_buf_release: assert property (p_buf_release)
    else $error("buffer read not completed");

  property p_drive_end;
    @(posedge core_clk) disable iff (!nrst)
    s_q.st == ST_DRIVE && s_q.rd_s[1] |=> ad_oe_n;
  endproperty
  a_drive_end: assert property (p_drive_end)
    else $error("bus still driven after read");

endmodule // mux_bus_processor_port

`default_nettype wire

// >>> verif/mux_cpu_model.sv
`default_nettype none

module mux_cpu_model (
  input  wire logic       core_clk,            // Core clock
  input  wire logic [7:0] ad_out,              // Device AD drive
  input  wire logic       ad_oe_n,             // Device drives AD when low
  input  wire logic       access_wait_ready,   // Low stretches the strobe
  output wire logic [7:0] ad_in,               // Resolved AD wire
  output logic            ale,                 // Address latch strobe
  output logic            cs_n,                // Chip select, low
  output logic            write_data_strobe_n, // Write strobe, low
  output logic            read_data_strobe_n,  // Read strobe, low
  output logic            hang                 // Ready wait ran out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] drv_q;
  logic       drv_en;

  // A released bus shows the inverse of the last value, so stale data fails
  assign ad_in = !ad_oe_n ? ad_out : (drv_en ? drv_q : ~drv_q);

  initial
  begin
    ale = 1'b0;
    cs_n = 1'b1;
    write_data_strobe_n = 1'b1;
    read_data_strobe_n = 1'b1;
    hang = 1'b0;
    drv_q = 8'h00;
    drv_en = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Strobe is held until ready is seen high, bounded
  task automatic wait_rdy;
    int k;
    k = 0;
    while (access_wait_ready !== 1'b1 && k < 300)
    begin
      cyc(1);
      k++;
    end
    if (access_wait_ready !== 1'b1) hang = 1'b1;
  endtask

  // Address sits on AD[6:1] around the ALE pulse
  task automatic addr_ph(input logic [5:0] a);
    drv_q = {1'b0, a, 1'b0};
    drv_en = 1'b1;
    ale = 1'b1;
    cyc(4);
    ale = 1'b0;
    cyc(4);
    drv_en = 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d,
                    input logic use_ale, input logic sel);
    if (use_ale) addr_ph(a);
    cs_n = !sel;
    drv_q = d;
    drv_en = 1'b1;
    write_data_strobe_n = 1'b0;
    cyc(6);
    wait_rdy();
    write_data_strobe_n = 1'b1;
    cyc(4);
    drv_en = 1'b0;
    cs_n = 1'b1;
    cyc(3);
  endtask

  // Hold sets how slowly this processor takes its read data
  task automatic rd(input logic [5:0] a, input int hold,
                    output logic [7:0] d);
    addr_ph(a);
    cs_n = 1'b0;
    read_data_strobe_n = 1'b0;
    cyc(hold);
    wait_rdy();
    d = ad_in;
    read_data_strobe_n = 1'b1;
    cyc(6);
    cs_n = 1'b1;
  endtask

endmodule // mux_cpu_model

`default_nettype wire

// >>> verif/mux_bus_processor_port_tb.sv
`default_nettype none

module mux_bus_processor_port_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk, nrst, ale, cs_n, wr_sn, rd_sn, ind_mode, ind_sel;
  logic ready, oe_n, reg_wr, reg_rd, buf_wr, buf_rd, buf_ack, hang;
  logic [7:0] ad_in, ad_out, reg_wdata, reg_rdata, buf_rdata, id_byte;
  logic [5:0] reg_addr;
  logic [2:0] irq_src, irq_out;
  logic xfer_src, xfer_irq, id_vld, id_done, crc_ok, cnt_upd;
  logic [15:0] blk_cnt, bufc;
  logic [7:0] bw_dat, wr_dat, rd_v;
  logic [5:0] wr_adr;
  int error_cnt, tests_run, wr_c, rd_c, bw_c, br_c, low_c, ack_c, buf_lat;

  mux_bus_processor_port #(.ID_BYTES(4)) dut (
    .core_clk(core_clk), .nrst(nrst), .ad_in(ad_in), .ad_out(ad_out),
    .ad_oe_n(oe_n), .ale(ale), .cs_n(cs_n), .write_data_strobe_n(wr_sn),
    .read_data_strobe_n(rd_sn), .indirect_mode(ind_mode),
    .indirect_data_sel(ind_sel), .access_wait_ready(ready),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .buf_wr(buf_wr),
    .buf_rd(buf_rd), .buf_ack(buf_ack), .buf_rdata(buf_rdata),
    .irq_src(irq_src), .buf_xfer_src(xfer_src),
    .interrupt_outputs(irq_out), .buffer_transfer_irq(xfer_irq),
    .id_byte_valid(id_vld), .id_byte(id_byte), .id_done(id_done),
    .id_crc_good(crc_ok), .cnt_update(cnt_upd), .block_count(blk_cnt),
    .buff_count(bufc));

  mux_cpu_model cpu (
    .core_clk(core_clk), .ad_out(ad_out), .ad_oe_n(oe_n),
    .access_wait_ready(ready), .ad_in(ad_in), .ale(ale), .cs_n(cs_n),
    .write_data_strobe_n(wr_sn), .read_data_strobe_n(rd_sn), .hang(hang));

  always #2.5 core_clk = ~core_clk;

  function automatic logic [7:0] regval(input logic [5:0] a);
    return {a, 2'b10} ^ 8'h5a;
  endfunction

  // Register file and buffer stand-ins, driven off the sampling edge
  always @(negedge core_clk)
  begin
    reg_rdata <= regval(reg_addr);
    buf_ack   <= ready === 1'b0 && ack_c >= buf_lat;
    if (ready === 1'b0)
      ack_c <= (ack_c >= buf_lat) ? 0 : ack_c + 1;
  end

  // Internal-side monitor: counts pulses and keeps the last write seen
  // Sampled mid-cycle, where each one-cycle pulse is settled
  always @(negedge core_clk)
  begin
    if (reg_wr === 1'b1)
    begin
      wr_c++;
      wr_adr = reg_addr;
      wr_dat = reg_wdata;
    end
    if (buf_wr === 1'b1)
    begin
      bw_c++;
      bw_dat = reg_wdata;
    end
    if (reg_rd === 1'b1) rd_c++;
    if (buf_rd === 1'b1) br_c++;
    if (ready === 1'b0) low_c++;
  end

  task automatic test_done;
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge hang)
  begin
    error_cnt++;
    $display("ERROR ready_wait expected 1 seen 0");
    test_done();
  end

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic clr;
    wr_c = 0; rd_c = 0; bw_c = 0; br_c = 0; low_c = 0;
  endtask

  // Back-to-back writes, then one with chip select off
  task automatic t_write;
    clr();
    cpu.wr(6'h05, 8'ha7, 1'b1, 1'b1);
    chk("wr_addr", 16'h05, wr_adr);
    chk("wr_data", 16'ha7, wr_dat);
    cpu.wr(6'h2e, 8'h5c, 1'b1, 1'b1);
    chk("wr_data2", 16'h2e5c, {wr_adr, wr_dat});
    cpu.wr(6'h07, 8'h11, 1'b1, 1'b0);
    chk("wr_count", 16'h2, wr_c[15:0]);
    chk("no_wait", 16'h0, low_c[15:0]);
  endtask

  // Prompt and slow reads; drive must end once the strobe is gone
  task automatic t_read;
    clr();
    cpu.rd(6'h12, 8, rd_v);
    chk("rd_fast", regval(6'h12), rd_v);
    cpu.rd(6'h21, 24, rd_v);
    chk("rd_slow", regval(6'h21), rd_v);
    chk("rd_release", 16'h1, oe_n);
    chk("rd_count", 16'h2, rd_c[15:0]);
    chk("no_wait", 16'h0, low_c[15:0]);
  endtask

  // Address register loaded first; an ALE pulse must not disturb it
  task automatic t_indirect;
    clr();
    ind_mode = 1'b1;
    ind_sel = 1'b0;
    cpu.wr(6'h00, 8'h14, 1'b0, 1'b1);
    ind_sel = 1'b1;
    cpu.addr_ph(6'h01);
    cpu.wr(6'h00, 8'h3c, 1'b0, 1'b1);
    chk("ind_write", {8'h01, 8'h3c}, {wr_c[7:0], wr_dat});
    chk("ind_addr", 16'h0a, wr_adr);
    ind_mode = 1'b0;
  endtask

  // Slow buffer answers stretch the strobe; register side stays quiet
  task automatic t_buffer;
    clr();
    buf_lat = 10;
    cpu.rd(6'h3f, 8, rd_v);
    chk("buf_rd_data", 16'hc3, rd_v);
    chk("buf_stretch", 16'h1, low_c >= 10);
    chk("buf_rd_req", 16'h0100, {br_c[7:0], rd_c[7:0]});
    buf_lat = 3;
    cpu.wr(6'h3f, 8'h99, 1'b1, 1'b1);
    chk("buf_wr", {8'h01, 8'h99}, {bw_c[7:0], bw_dat});
    chk("buf_no_reg", 16'h0, wr_c[15:0]);
  endtask

  // Every pattern on the three interrupt lines, with the transfer line following line 0
  task automatic t_irq;
    for (int i = 0; i < 8; i++)
    begin
      irq_src = i[2:0];
      xfer_src = i[0];
      cyc(3);
      chk("irq_lines", {12'h0, i[0], i[2:0]}, {xfer_irq, irq_out});
    end
    irq_src = 3'h0;
    xfer_src = 1'b0;
  endtask

  // Good ID fills the window and flags; counts are a frozen snapshot
  task automatic t_capture;
    logic [7:0] e [8];
    e = '{8'h71, 8'h72, 8'h73, 8'h74, 8'h34, 8'h12, 8'hc5, 8'h00};
    for (int i = 0; i < 4; i++)
    begin
      id_vld = 1'b1;
      id_byte = e[i];
      cyc(1);
    end
    id_vld = 1'b0;
    id_done = 1'b1;
    crc_ok = 1'b1;
    cyc(1);
    id_done = 1'b0;
    blk_cnt = 16'h1234;
    bufc = 16'h00c5;
    cnt_upd = 1'b1;
    cyc(1);
    cnt_upd = 1'b0;
    blk_cnt = 16'hffff;
    cyc(3);
    chk("id_full_irq", 16'h1, irq_out[0]);
    for (int i = 0; i < 8; i++)
    begin
      cpu.rd(6'h30 + 6'(i < 4 ? i : i + 4), 8, rd_v);
      chk("capture", e[i], rd_v);
    end
    cpu.rd(6'h3c, 8, rd_v);
    chk("cap_stat_full", 16'h01, rd_v);
    // Clear the full flag and rearm in one write
    cpu.wr(6'h3c, 8'h03, 1'b1, 1'b1);
    cyc(3);
    chk("id_full_clr", 16'h0, irq_out[0]);
    cpu.rd(6'h3c, 8, rd_v);
    chk("cap_stat_arm", 16'h02, rd_v);
  endtask

  initial
  begin
    core_clk = 1'b0; nrst = 1'b0; ind_mode = 1'b0; ind_sel = 1'b0;
    buf_rdata = 8'hc3; irq_src = 3'h0; xfer_src = 1'b0; id_vld = 1'b0;
    id_byte = 8'h00; id_done = 1'b0; crc_ok = 1'b0; cnt_upd = 1'b0;
    blk_cnt = 16'h0; bufc = 16'h0; reg_rdata = 8'h00; buf_ack = 1'b0;
    error_cnt = 0; tests_run = 0; ack_c = 0; buf_lat = 3;
    clr();
    repeat (8) @(negedge core_clk);
    nrst = 1'b1;
    cyc(2);
    t_write();
    t_read();
    t_indirect();
    t_buffer();
    t_irq();
    t_capture();
    test_done();
  end

endmodule // mux_bus_processor_port_tb

`default_nettype wire
